// ### shared/usb_list_regs_pkg.sv
// Offsets, field positions, reset values and timing for the list and frame register bank.
// Assumes an 8-bit word-aligned byte address and a 100 MHz register clock.
package usb_list_regs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN_CLEAR = 8'h08;
  localparam logic [7:0] OFS_COMM_AREA    = 8'h0c;
  localparam logic [7:0] OFS_PERIODIC_CUR = 8'h10;
  localparam logic [7:0] OFS_CTRL_HEAD    = 8'h14;
  localparam logic [7:0] OFS_CTRL_CUR     = 8'h18;
  localparam logic [7:0] OFS_BULK_HEAD    = 8'h1c;
  localparam logic [7:0] OFS_BULK_CUR     = 8'h20;
  localparam logic [7:0] OFS_DONE_TOP     = 8'h24;
  localparam logic [7:0] OFS_FRAME_CFG    = 8'h28;
  localparam logic [7:0] OFS_FRAME_LEFT   = 8'h2c;
  localparam logic [7:0] OFS_FRAME_NUM    = 8'h30;

  // Interrupt field positions
  localparam int SCHED_OVERRUN_BIT   = 0;
  localparam int COMPLETED_QUEUE_BIT = 1;
  localparam int FRAME_BEGIN_BIT     = 2;
  localparam int RESUME_SEEN_BIT     = 3;
  localparam int FATAL_BUS_BIT       = 4;
  localparam int COUNT_WRAP_BIT      = 5;
  localparam int HUB_CHANGE_BIT      = 6;
  localparam int OWNER_SWITCH_BIT    = 30;
  localparam int MASTER_GATE_BIT     = 31;
  localparam int NUM_EVENTS          = 7;

  // Pointer field layout
  localparam int COMM_AREA_LSB = 8;
  localparam int DESC_PTR_LSB  = 4;

  // Frame interval layout
  localparam int FLIP_BIT       = 31;
  localparam int MAX_PKT_MSB    = 30;
  localparam int MAX_PKT_LSB    = 16;
  localparam int FRAME_LEN_BITS = 14;

  // Reset values
  localparam logic [13:0] FRAME_LEN_RESET = 14'h2edf;
  localparam logic [14:0] MAX_PKT_RESET   = 15'h0000;
  localparam logic [31:0] PTR_RESET       = 32'h0000_0000;

  // Bit-time rate derived from the register clock
  localparam int CLK_RATE_MHZ = 100;
  localparam int BIT_RATE_MHZ = 12;

endpackage : usb_list_regs_pkg

// ### src/usb_host_list_frame_regs.sv
// List pointer, interrupt enable and frame timing registers of a USB host controller.
// Assumes a single-cycle register port and a list engine on the same clock.
//
// Contract
// - Overrun interrupt needs its enable and master gate
// - Writing one to enable-clear drops that enable
// - Enable-clear register always reads zero
// - Ownership bit is read-only zero, no effect
// - Comm area base keeps bits 31..8 only
// - Descriptor pointers keep bits 31..4 only
// - Periodic cursor read-only, reset zero, engine-updated
// - Control cursor zeroed when list end empty
// - Bulk cursor zeroed when list end empty
// - Control and bulk heads are plain storage
// - Done top read-only, engine-updated, zero only at reset
// - Frame length field bits 13..0, reset 0x2edf
// - Max packet bits 30..16, read/write, reset zero
// - Read-only count of bit times left
// - Frame start reloads count and copies flip bit
// - Frame counter increments, wraps, sets frame-begin flag
module usb_host_list_frame_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [31:0]       WR_DATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output logic      [31:0]       RD_DATA,
  input  wire logic              FRAME_RUN,
  input  wire logic              SCHED_OVERRUN,
  input  wire logic              RESUME_SEEN,
  input  wire logic              FATAL_BUS_ERROR,
  input  wire logic              HUB_CHANGE,
  input  wire logic              PERIODIC_WE,
  input  wire logic [31:0]       PERIODIC_ADDR,
  input  wire logic              CTRL_CUR_WE,
  input  wire logic [31:0]       CTRL_CUR_ADDR,
  input  wire logic              CTRL_DRAINED,
  input  wire logic              BULK_CUR_WE,
  input  wire logic [31:0]       BULK_CUR_ADDR,
  input  wire logic              BULK_DRAINED,
  input  wire logic              DONE_WE,
  input  wire logic [31:0]       DONE_ADDR,
  output logic      [31:0]       COMM_AREA,
  output logic      [31:0]       CTRL_HEAD,
  output logic      [31:0]       BULK_HEAD,
  output logic      [31:0]       CTRL_CURSOR,
  output logic      [31:0]       BULK_CURSOR,
  output logic      [31:0]       PERIODIC_CURSOR,
  output logic      [15:0]       FRAME_NUMBER,
  output logic                   FRAME_START,
  output logic                   IRQ
);

  function automatic logic [31:0] desc_ptr(input logic [31:0] v);
    desc_ptr = {v[31:usb_list_regs_pkg::DESC_PTR_LSB], 4'h0};
  endfunction : desc_ptr

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  logic [usb_list_regs_pkg::NUM_EVENTS-1:0] irq_status;
  logic [usb_list_regs_pkg::NUM_EVENTS-1:0] irq_enable;
  logic [usb_list_regs_pkg::NUM_EVENTS-1:0] event_set;
  logic                                     master_irq_gate;
  logic [31:0]                              completed_top_addr;
  logic                                     interval_flip;
  logic [14:0]                              max_packet_bits;
  logic [13:0]                              frame_length;
  logic [13:0]                              bit_times_left;
  logic                                     left_count_flip;
  logic [15:0]                              sof_counter;
  logic [6:0]                               bit_acc;
  logic                                     bit_tick;
  logic                                     count_wrap;
  logic [31:0]                              next_rd_data;

  // Register writes
  logic wr_status;
  logic wr_enable;
  logic wr_en_clear;
  assign wr_status   = WR_STB && hit(ADDR, usb_list_regs_pkg::OFS_IRQ_STATUS);
  assign wr_enable   = WR_STB && hit(ADDR, usb_list_regs_pkg::OFS_IRQ_ENABLE);
  assign wr_en_clear = WR_STB && hit(ADDR, usb_list_regs_pkg::OFS_IRQ_EN_CLEAR);

  // Bit-time tick: 12 of every 100 clocks, spread evenly
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_acc <= 7'h00;
    end else if (bit_acc >= 7'(usb_list_regs_pkg::CLK_RATE_MHZ
                              - usb_list_regs_pkg::BIT_RATE_MHZ)) begin
      bit_acc <= bit_acc - 7'(usb_list_regs_pkg::CLK_RATE_MHZ
                              - usb_list_regs_pkg::BIT_RATE_MHZ);
    end else begin
      bit_acc <= bit_acc + 7'(usb_list_regs_pkg::BIT_RATE_MHZ);
    end
  end
  assign bit_tick = bit_acc >= 7'(usb_list_regs_pkg::CLK_RATE_MHZ
                                  - usb_list_regs_pkg::BIT_RATE_MHZ);

  // Frame starts when the count has run out
  assign FRAME_START = FRAME_RUN && bit_tick && (bit_times_left == 14'h0000);
  // Wrap flag follows counter bit 15, so it sets twice per full count
  assign count_wrap  = FRAME_START && (sof_counter[14:0] == 15'h7fff);

  // Remaining-time counter; the length is sampled only at reload
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_times_left  <= 14'h0000;
      left_count_flip <= 1'b0;
    end else if (!FRAME_RUN) begin
      bit_times_left  <= 14'h0000;
    end else if (FRAME_START) begin
      bit_times_left  <= frame_length;
      left_count_flip <= interval_flip;
    end else if (bit_tick) begin
      bit_times_left  <= bit_times_left - 14'h0001;
    end
  end

  // Frame counter wraps naturally at 16 bits
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sof_counter <= 16'h0000;
    end else if (FRAME_START) begin
      sof_counter <= sof_counter + 16'h0001;
    end
  end
  assign FRAME_NUMBER = sof_counter;

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    event_set = '0;
    event_set[usb_list_regs_pkg::SCHED_OVERRUN_BIT]   = SCHED_OVERRUN;
    event_set[usb_list_regs_pkg::COMPLETED_QUEUE_BIT] = DONE_WE;
    event_set[usb_list_regs_pkg::FRAME_BEGIN_BIT]     = FRAME_START;
    event_set[usb_list_regs_pkg::RESUME_SEEN_BIT]     = RESUME_SEEN;
    event_set[usb_list_regs_pkg::FATAL_BUS_BIT]       = FATAL_BUS_ERROR;
    event_set[usb_list_regs_pkg::COUNT_WRAP_BIT]      = count_wrap;
    event_set[usb_list_regs_pkg::HUB_CHANGE_BIT]      = HUB_CHANGE;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~(wr_status ? WR_DATA[6:0] : 7'h00)) | event_set;
    end
  end

  // Enables: set through one offset, dropped through the clear offset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_enable      <= '0;
      master_irq_gate <= 1'b0;
    end else if (wr_enable) begin
      irq_enable      <= irq_enable | WR_DATA[6:0];
      master_irq_gate <= master_irq_gate | WR_DATA[usb_list_regs_pkg::MASTER_GATE_BIT];
    end else if (wr_en_clear) begin
      irq_enable      <= irq_enable & ~WR_DATA[6:0];
      master_irq_gate <= master_irq_gate
                         & ~WR_DATA[usb_list_regs_pkg::MASTER_GATE_BIT];
    end
  end

  // Level interrupt, gated by the master enable
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= master_irq_gate && |(next_status() & irq_enable);
    end
  end

  function automatic logic [6:0] next_status();
    next_status = irq_status;
  endfunction : next_status

  // Software-owned pointers and frame configuration
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      COMM_AREA       <= usb_list_regs_pkg::PTR_RESET;
      CTRL_HEAD       <= usb_list_regs_pkg::PTR_RESET;
      BULK_HEAD       <= usb_list_regs_pkg::PTR_RESET;
      interval_flip   <= 1'b0;
      max_packet_bits <= usb_list_regs_pkg::MAX_PKT_RESET;
      frame_length    <= usb_list_regs_pkg::FRAME_LEN_RESET;
    end else if (WR_STB) begin
      if (hit(ADDR, usb_list_regs_pkg::OFS_COMM_AREA)) begin
        COMM_AREA <= {WR_DATA[31:usb_list_regs_pkg::COMM_AREA_LSB], 8'h00};
      end
      if (hit(ADDR, usb_list_regs_pkg::OFS_CTRL_HEAD)) begin
        CTRL_HEAD <= desc_ptr(WR_DATA);
      end
      if (hit(ADDR, usb_list_regs_pkg::OFS_BULK_HEAD)) begin
        BULK_HEAD <= desc_ptr(WR_DATA);
      end
      if (hit(ADDR, usb_list_regs_pkg::OFS_FRAME_CFG)) begin
        interval_flip   <= WR_DATA[usb_list_regs_pkg::FLIP_BIT];
        max_packet_bits <= WR_DATA[usb_list_regs_pkg::MAX_PKT_MSB:
                                   usb_list_regs_pkg::MAX_PKT_LSB];
        frame_length    <= WR_DATA[13:0];
      end
    end
  end

  // Cursors: the engine wins over a software write in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CTRL_CURSOR <= usb_list_regs_pkg::PTR_RESET;
    end else if (CTRL_DRAINED) begin
      CTRL_CURSOR <= usb_list_regs_pkg::PTR_RESET;
    end else if (CTRL_CUR_WE) begin
      CTRL_CURSOR <= desc_ptr(CTRL_CUR_ADDR);
    end else if (WR_STB && hit(ADDR, usb_list_regs_pkg::OFS_CTRL_CUR)) begin
      CTRL_CURSOR <= desc_ptr(WR_DATA);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BULK_CURSOR <= usb_list_regs_pkg::PTR_RESET;
    end else if (BULK_DRAINED) begin
      BULK_CURSOR <= usb_list_regs_pkg::PTR_RESET;
    end else if (BULK_CUR_WE) begin
      BULK_CURSOR <= desc_ptr(BULK_CUR_ADDR);
    end else if (WR_STB && hit(ADDR, usb_list_regs_pkg::OFS_BULK_CUR)) begin
      BULK_CURSOR <= desc_ptr(WR_DATA);
    end
  end

  // Engine-only pointers; software writes have no effect
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PERIODIC_CURSOR <= usb_list_regs_pkg::PTR_RESET;
    end else if (PERIODIC_WE) begin
      PERIODIC_CURSOR <= desc_ptr(PERIODIC_ADDR);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      completed_top_addr <= usb_list_regs_pkg::PTR_RESET;
    end else if (DONE_WE) begin
      completed_top_addr <= desc_ptr(DONE_ADDR);
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    next_rd_data = 32'h0000_0000;
    if (RD_STB) begin
      if (hit(ADDR, usb_list_regs_pkg::OFS_IRQ_STATUS)) begin
        next_rd_data[6:0] = irq_status;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_IRQ_ENABLE)) begin
        next_rd_data[6:0] = irq_enable;
        next_rd_data[usb_list_regs_pkg::MASTER_GATE_BIT] = master_irq_gate;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_IRQ_EN_CLEAR)) begin
        next_rd_data = 32'h0000_0000;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_COMM_AREA)) begin
        next_rd_data = COMM_AREA;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_PERIODIC_CUR)) begin
        next_rd_data = PERIODIC_CURSOR;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_CTRL_HEAD)) begin
        next_rd_data = CTRL_HEAD;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_CTRL_CUR)) begin
        next_rd_data = CTRL_CURSOR;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_BULK_HEAD)) begin
        next_rd_data = BULK_HEAD;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_BULK_CUR)) begin
        next_rd_data = BULK_CURSOR;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_DONE_TOP)) begin
        next_rd_data = completed_top_addr;
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_FRAME_CFG)) begin
        next_rd_data = {interval_flip, max_packet_bits, 2'b00, frame_length};
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_FRAME_LEFT)) begin
        next_rd_data = {left_count_flip, 17'h00000, bit_times_left};
      end else if (hit(ADDR, usb_list_regs_pkg::OFS_FRAME_NUM)) begin
        next_rd_data = {16'h0000, sof_counter};
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RD_DATA <= 32'h0000_0000;
    end else begin
      RD_DATA <= next_rd_data;
    end
  end

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  chk_overrun_gate_off: assert property (
    (irq_status[usb_list_regs_pkg::SCHED_OVERRUN_BIT] && !master_irq_gate)
      && (irq_status[6:1] == 6'h00) |=> !IRQ)
    else $error("Overrun interrupt passed a closed master gate");

  chk_clear_master: assert property (
    wr_en_clear && WR_DATA[usb_list_regs_pkg::MASTER_GATE_BIT] |=> !master_irq_gate ##1 !IRQ)
    else $error("Enable-clear write left master gate set");

  chk_clear_reads_zero: assert property (
    RD_STB && hit(ADDR, usb_list_regs_pkg::OFS_IRQ_EN_CLEAR) |=> RD_DATA == 32'h0000_0000)
    else $error("Enable-clear register read nonzero");

  chk_comm_low_zero: assert property (
    RD_STB && hit(ADDR, usb_list_regs_pkg::OFS_COMM_AREA) |=> RD_DATA[7:0] == 8'h00)
    else $error("Comm area low byte not zero");

  chk_periodic_ro: assert property (
    WR_STB && !PERIODIC_WE |=> $stable(PERIODIC_CURSOR))
    else $error("Periodic cursor moved without engine update");

  chk_ctrl_drained: assert property (
    CTRL_DRAINED |=> CTRL_CURSOR == 32'h0000_0000)
    else $error("Control cursor not zeroed at empty list end");

  chk_bulk_drained: assert property (
    BULK_DRAINED |=> BULK_CURSOR == 32'h0000_0000)
    else $error("Bulk cursor not zeroed at empty list end");

  chk_done_update: assert property (
    DONE_WE |=> completed_top_addr == desc_ptr($past(DONE_ADDR))
      && irq_status[usb_list_regs_pkg::COMPLETED_QUEUE_BIT])
    else $error("Done top or its flag not updated");

  chk_frame_reload: assert property (
    FRAME_START |=> bit_times_left == $past(frame_length)
      && left_count_flip == $past(interval_flip))
    else $error("Frame start did not reload remaining count");

  chk_frame_count: assert property (
    FRAME_START |=> sof_counter == $past(sof_counter) + 16'h0001
      && irq_status[usb_list_regs_pkg::FRAME_BEGIN_BIT])
    else $error("Frame counter or frame-begin flag wrong");

  chk_left_countdown: assert property (
    FRAME_RUN && bit_tick && bit_times_left != 14'h0000 ##1 FRAME_RUN
      |-> bit_times_left == $past(bit_times_left) - 14'h0001)
    else $error("Remaining count did not step down");

  chk_clear_only_ones: assert property (
    wr_en_clear |=> irq_enable == ($past(irq_enable) & ~$past(WR_DATA[6:0])))
    else $error("Enable-clear write changed an enable written as zero");

  chk_cfg_reserved: assert property (
    RD_STB && hit(ADDR, usb_list_regs_pkg::OFS_FRAME_CFG) |=> RD_DATA[15:14] == 2'b00)
    else $error("Frame interval reserved bits read nonzero");

  chk_owner_bit_zero: assert property (
    RD_STB && hit(ADDR, usb_list_regs_pkg::OFS_IRQ_ENABLE)
      |=> !RD_DATA[usb_list_regs_pkg::OWNER_SWITCH_BIT])
    else $error("Ownership bit read nonzero");

  chk_ptr_low_zero: assert property (
    (CTRL_HEAD[3:0] | BULK_HEAD[3:0] | CTRL_CURSOR[3:0] | BULK_CURSOR[3:0]
      | PERIODIC_CURSOR[3:0]) == 4'h0)
    else $error("Descriptor pointer low bits nonzero");

  cov_frame_start: cover property (FRAME_START ##[100:400] FRAME_START);
  cov_event_clear: cover property (wr_status && |event_set);
  cov_ctrl_drain: cover property (CTRL_CUR_WE ##[1:10] CTRL_DRAINED);
  cov_irq_rise: cover property (!IRQ ##1 IRQ);
  cov_count_wrap: cover property (count_wrap);

endmodule : usb_host_list_frame_regs

// ### test/list_engine_model.sv
// Behavioural list engine and event source facing the register bank.
// Assumes the bench calls fire() one request at a time, on CLK.
module list_engine_model (
  input  wire logic        clk,
  output logic      [9:0]  strobe,
  output logic      [31:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    strobe   = 10'h000;
    addr_out = 32'h0000_0000;
  end

  // Strobes: 0 periodic, 1 ctrl, 2 bulk, 3 done, 4/5 drained, 6..9 events
  task automatic fire(input int idx, input logic [31:0] a);
    @(posedge clk);
    strobe[idx] <= 1'b1;
    addr_out    <= a;
    @(posedge clk);
    strobe[idx] <= 1'b0;
    // Stale address must not look valid after release
    addr_out    <= ~a;
  endtask : fire
endmodule : list_engine_model

// ### test/usb_host_list_frame_regs_tb_top.sv
// Self-checking bench for the list and frame register bank.
// Assumes the engine model beside it and the package register offsets.
module usb_host_list_frame_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        arst_n;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rd_data;
  logic        frame_run;
  logic [9:0]  eng_stb;
  logic [31:0] eng_addr;
  logic [31:0] ctrl_cursor;
  logic [31:0] comm_area;
  logic [31:0] ctrl_head;
  logic [31:0] bulk_head;
  logic [31:0] bulk_cursor;
  logic [31:0] periodic_cursor;
  logic [15:0] frame_number;
  logic        frame_start;
  logic        irq;
  int          n_errors;
  int          num_checks;
  int          cyc;

  usb_host_list_frame_regs #(.ADDR_W(8)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RD_DATA(rd_data), .FRAME_RUN(frame_run),
    .SCHED_OVERRUN(eng_stb[6]), .RESUME_SEEN(eng_stb[7]), .FATAL_BUS_ERROR(eng_stb[8]),
    .HUB_CHANGE(eng_stb[9]), .PERIODIC_WE(eng_stb[0]), .PERIODIC_ADDR(eng_addr),
    .CTRL_CUR_WE(eng_stb[1]), .CTRL_CUR_ADDR(eng_addr), .CTRL_DRAINED(eng_stb[4]),
    .BULK_CUR_WE(eng_stb[2]), .BULK_CUR_ADDR(eng_addr), .BULK_DRAINED(eng_stb[5]),
    .DONE_WE(eng_stb[3]), .DONE_ADDR(eng_addr), .COMM_AREA(comm_area), .CTRL_HEAD(ctrl_head),
    .BULK_HEAD(bulk_head), .CTRL_CURSOR(ctrl_cursor), .BULK_CURSOR(bulk_cursor),
    .PERIODIC_CURSOR(periodic_cursor), .FRAME_NUMBER(frame_number), .FRAME_START(frame_start),
    .IRQ(irq));

  list_engine_model i_eng (.clk(clk), .strobe(eng_stb), .addr_out(eng_addr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Hang guard; the frame scenarios need well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      $display("wrong value at %0t: run did not finish", $time);
      n_errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clk);
    wr_stb  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rdchk

  // IRQ lags status by one cycle
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk);
    #1 check(32'(irq), 32'(exp));
  endtask : irq_is

  task automatic wait_start(output int stamp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (frame_start !== 1'b1 && n < 1000);
    check(32'(frame_start), 32'h1);
    stamp = cyc;
  endtask : wait_start

  task automatic test_pointers();
    logic [7:0]  ofs [7];
    logic [31:0] msk [7];
    ofs = '{usb_list_regs_pkg::OFS_COMM_AREA, usb_list_regs_pkg::OFS_CTRL_HEAD,
            usb_list_regs_pkg::OFS_BULK_HEAD, usb_list_regs_pkg::OFS_CTRL_CUR,
            usb_list_regs_pkg::OFS_BULK_CUR, usb_list_regs_pkg::OFS_PERIODIC_CUR,
            usb_list_regs_pkg::OFS_DONE_TOP};
    msk = '{32'hffff_ff00, 32'hffff_fff0, 32'hffff_fff0, 32'hffff_fff0,
            32'hffff_fff0, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 7; i++) begin
      rdchk(ofs[i], 32'h0000_0000);
      wr(ofs[i], 32'hffff_ffff);
      rdchk(ofs[i], msk[i]);
    end
    check(comm_area, 32'hffff_ff00);
    check(ctrl_head, 32'hffff_fff0);
    check(bulk_head, 32'hffff_fff0);
    check(bulk_cursor, 32'hffff_fff0);
    check(periodic_cursor, 32'h0000_0000);
    rdchk(8'hfc, 32'h0000_0000);
    rdchk(usb_list_regs_pkg::OFS_FRAME_CFG, 32'h0000_2edf);
    rdchk(usb_list_regs_pkg::OFS_FRAME_LEFT, 32'h0000_0000);
  endtask : test_pointers

  task automatic test_engine();
    i_eng.fire(0, 32'h1234_567f);
    rdchk(usb_list_regs_pkg::OFS_PERIODIC_CUR, 32'h1234_5670);
    i_eng.fire(1, 32'habcd_0019);
    rdchk(usb_list_regs_pkg::OFS_CTRL_CUR, 32'habcd_0010);
    i_eng.fire(4, 32'h0000_0000);
    #1 check(ctrl_cursor, 32'h0000_0000);
    i_eng.fire(2, 32'h5555_aaa5);
    rdchk(usb_list_regs_pkg::OFS_BULK_CUR, 32'h5555_aaa0);
    i_eng.fire(5, 32'h0000_0000);
    rdchk(usb_list_regs_pkg::OFS_BULK_CUR, 32'h0000_0000);
    i_eng.fire(3, 32'h8765_4321);
    rdchk(usb_list_regs_pkg::OFS_DONE_TOP, 32'h8765_4320);
    wr(usb_list_regs_pkg::OFS_IRQ_STATUS, 32'h0000_007f);
  endtask : test_engine

  task automatic test_irq();
    logic [31:0] en;
    wr(usb_list_regs_pkg::OFS_IRQ_ENABLE, 32'h8000_0001);
    i_eng.fire(6, 32'h0000_0000);
    irq_is(1'b1);
    wr(usb_list_regs_pkg::OFS_IRQ_EN_CLEAR, 32'h4000_0000);
    irq_is(1'b1);
    wr(usb_list_regs_pkg::OFS_IRQ_EN_CLEAR, 32'h8000_0000);
    irq_is(1'b0);
    wr(usb_list_regs_pkg::OFS_IRQ_ENABLE, 32'h8000_0000);
    wr(usb_list_regs_pkg::OFS_IRQ_EN_CLEAR, 32'h0000_0001);
    wr(usb_list_regs_pkg::OFS_IRQ_ENABLE, 32'h8000_0000);
    irq_is(1'b0);
    wr(usb_list_regs_pkg::OFS_IRQ_STATUS, 32'h0000_007f);
    wr(usb_list_regs_pkg::OFS_IRQ_ENABLE, 32'hffff_ffff);
    en = 32'h8000_007f;
    rdchk(usb_list_regs_pkg::OFS_IRQ_ENABLE, en);
    rdchk(usb_list_regs_pkg::OFS_IRQ_EN_CLEAR, 32'h0000_0000);
    for (int b = 0; b < 8; b++) begin
      wr(usb_list_regs_pkg::OFS_IRQ_EN_CLEAR, (b == 7) ? 32'h8000_0000 : 32'(1) << b);
      en = (b == 7) ? 32'h0000_0000 : en & ~(32'(1) << b);
      rdchk(usb_list_regs_pkg::OFS_IRQ_ENABLE, en);
    end
  endtask : test_irq

  // Events not used elsewhere: resume, fatal error, hub change
  task automatic test_events();
    wr(usb_list_regs_pkg::OFS_IRQ_ENABLE, 32'h8000_0040);
    for (int i = 7; i < 10; i++) begin
      i_eng.fire(i, 32'h0000_0000);
    end
    irq_is(1'b1);
    rdchk(usb_list_regs_pkg::OFS_IRQ_STATUS, 32'h0000_0058);
    wr(usb_list_regs_pkg::OFS_IRQ_EN_CLEAR, 32'h0000_0040);
    irq_is(1'b0);
    wr(usb_list_regs_pkg::OFS_IRQ_STATUS, 32'hffff_ff58);
    rdchk(usb_list_regs_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
  endtask : test_events

  task automatic test_frame();
    int t0;
    int t1;
    int t2;
    logic [15:0] fn;
    wr(usb_list_regs_pkg::OFS_FRAME_CFG, 32'h8123_c028);
    rdchk(usb_list_regs_pkg::OFS_FRAME_CFG, 32'h8123_0028);
    @(posedge clk);
    frame_run <= 1'b1;
    wait_start(t0);
    fn = frame_number;
    rdchk(usb_list_regs_pkg::OFS_FRAME_LEFT, 32'h8000_0028);
    check(32'(frame_number), 32'(fn + 16'h0001));
    rdchk(usb_list_regs_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    // Shorter frame with the flip bit inverted, written mid-frame
    wr(usb_list_regs_pkg::OFS_FRAME_CFG, 32'h0123_0014);
    wait_start(t1);
    check(32'((t1 - t0) inside {[341:342]}), 32'h1);
    rdchk(usb_list_regs_pkg::OFS_FRAME_LEFT, 32'h0000_0014);
    wait_start(t2);
    check(32'((t2 - t1) inside {[175:176]}), 32'h1);
    frame_run <= 1'b0;
  endtask : test_frame

  initial begin
    arst_n     = 1'b0;
    addr       = 8'h00;
    wr_data    = 32'h0000_0000;
    wr_stb     = 1'b0;
    rd_stb     = 1'b0;
    frame_run  = 1'b0;
    n_errors   = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    test_pointers();
    test_engine();
    test_irq();
    test_events();
    test_frame();
    results();
  end
endmodule : usb_host_list_frame_regs_tb_top
